// ===== rtl/dam_channel.sv
/*
 One alarm channel: hysteresis comparator, blocking and delay timer.
 Assumes tick_ms and cycle_en are one-cycle pulses of clk.
*/
`timescale 1ns/100ps
`default_nettype none
module dam_channel (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Timing
  input wire logic cycle_en,
  input wire logic tick_ms,
  // Settings and inputs
  input wire logic enable_n,
  input wire logic [13:0] limit,
  input wire logic [18:0] delay_steps,
  input wire logic [13:0] value,
  input wire logic block,
  // Outputs
  output logic start_r,
  output logic alarm_r,
  output logic blocked_r
);
  import dam_pkg::*;
  logic pick_r;
  logic eval_r;
  logic [21:0] ms_cnt_r;
  logic [21:0] release_lvl;
  logic [21:0] delay_ms;
  assign release_lvl = 22'((32'(limit) * REL_NUM) / REL_DEN);
  assign delay_ms = 22'(32'(delay_steps) * DELAY_STEP_MS);
  // Pick-up with fixed release hysteresis
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pick_r <= 1'b0;
    end else if (cycle_en) begin
      if (enable_n != ENABLED) begin
        pick_r <= 1'b0;
      end else if (value > limit) begin
        pick_r <= 1'b1;
      end else if (22'(value) < release_lvl) begin
        pick_r <= 1'b0;
      end
    end
  end
  // Start and blocked update only once the new pick-up is in, so a fresh
  // block never meets a stale pick-up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eval_r <= 1'b0;
      start_r <= 1'b0;
      blocked_r <= 1'b0;
    end else begin
      eval_r <= cycle_en;
      if (eval_r) begin
        start_r <= pick_r && !block;
        blocked_r <= pick_r && block;
      end
    end
  end
  // Definite delay timer in milliseconds
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ms_cnt_r <= '0;
      alarm_r <= 1'b0;
    end else if (!start_r) begin
      ms_cnt_r <= '0;
      alarm_r <= 1'b0;
    end else if (ms_cnt_r >= delay_ms) begin
      alarm_r <= 1'b1;
    end else if (tick_ms) begin
      ms_cnt_r <= ms_cnt_r + 22'h000001;
    end
  end
endmodule : dam_channel
`default_nettype wire

// ===== rtl/dam_log.sv
/*
 Twelve-entry circular operation log.
 Assumes one write pulse per entry; read is combinational by index.
*/
`timescale 1ns/100ps
`default_nettype none
module dam_log (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write side
  input wire logic wr_en,
  input wire logic [63:0] wr_data,
  // Read side
  input wire logic [3:0] rd_idx,
  output logic [63:0] rd_data,
  output logic [3:0] count_r,
  output logic [3:0] head_r
);
  import dam_pkg::*;
  logic [63:0] mem [LOG_DEPTH];
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[head_r] <= wr_data;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      head_r <= '0;
      count_r <= '0;
    end else if (wr_en) begin
      head_r <= (head_r == 4'(LOG_DEPTH - 1)) ? 4'h0 : head_r + 4'h1;
      if (count_r != 4'(LOG_DEPTH)) begin
        count_r <= count_r + 4'h1;
      end
    end
  end
  assign rd_data = (rd_idx < 4'(LOG_DEPTH)) ? mem[rd_idx] : 64'h0;
endmodule : dam_log
`default_nettype wire

// ===== rtl/dam_top.sv
/*
 Distortion alarm monitor top: three channels, status, events and log.
 Assumes values arrive as 14-bit 0.01 % units with a new_values pulse
 every 5 ms, and that settings are held stable by the host.
*/
`timescale 1ns/100ps
`default_nettype none
module dam_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Measurements from the spectrum stage
  input wire logic new_values,
  input wire logic [13:0] ampl_l1,
  input wire logic [13:0] ampl_l2,
  input wire logic [13:0] ampl_l3,
  input wire logic [13:0] ampl_r1,
  input wire logic [13:0] ampl_r2,
  input wire logic [13:0] power_l1,
  input wire logic [13:0] power_l2,
  input wire logic [13:0] power_l3,
  input wire logic [13:0] power_r1,
  input wire logic [13:0] power_r2,
  // Static and group settings
  input wire logic [1:0] ratio_mode,
  input wire logic [2:0] setting_group,
  input wire logic [dam_pkg::NCH*dam_pkg::NGRP-1:0] enable_n_grp,
  input wire logic [dam_pkg::NCH*dam_pkg::NGRP*14-1:0] limit_grp,
  input wire logic [dam_pkg::NCH*dam_pkg::NGRP*19-1:0] delay_grp,
  // Blocking
  input wire logic block_in,
  input wire logic force_mode,
  input wire logic force_block,
  // Event mask and wall time
  input wire logic [dam_pkg::NEV-1:0] event_mask,
  input wire logic [39:0] time_ms_in,
  // Outputs
  output logic [dam_pkg::NCH-1:0] start_out_r,
  output logic [dam_pkg::NCH-1:0] alarm_out_r,
  output logic blocked_out_r,
  output var dam_pkg::dam_state_t monitor_state_code_r,
  // Event stream
  output logic ev_valid_r,
  output logic [3:0] ev_id_r,
  output logic [39:0] ev_time_r,
  output logic [41:0] ev_data_r,
  output logic [2:0] ev_group_r,
  // Log read port
  input wire logic [3:0] log_idx,
  output logic [63:0] log_data_r,
  output logic [3:0] log_count_r
);
  import dam_pkg::*;

  logic [25:0] ms_div_r;
  logic tick_ms_r;
  logic [40:0] stamp_r;
  logic block_s_r;
  logic cycle_r;
  logic [13:0] val [NCH+2];
  logic [13:0] chan_val [NCH];
  logic [NCH-1:0] ch_start;
  logic [NCH-1:0] ch_alarm;
  logic [NCH-1:0] ch_blocked;
  logic [NEV-1:0] now_v;
  logic [NEV-1:0] prev_r;
  logic [NEV-1:0] rise;
  logic [NEV-1:0] fall;
  logic [NEV-1:0] pend_r;
  logic [3:0] pick_id;
  logic pick_any;
  logic [41:0] snap;
  logic log_wr;
  logic [63:0] log_wd;
  logic [63:0] log_rd;
  logic [3:0] log_cnt;

  // Millisecond tick and time stamp
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ms_div_r <= '0;
      tick_ms_r <= 1'b0;
    end else if (ms_div_r == 26'(MS_CYCLES - 1)) begin
      ms_div_r <= '0;
      tick_ms_r <= 1'b1;
    end else begin
      ms_div_r <= ms_div_r + 26'h0000001;
      tick_ms_r <= 1'b0;
    end
  end
  assign stamp_r = {1'b0, time_ms_in};

  // Block sampled first, then the channels evaluate next cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      block_s_r <= 1'b0;
      cycle_r <= 1'b0;
    end else begin
      cycle_r <= new_values;
      if (new_values) begin
        block_s_r <= force_mode ? force_block : block_in;
      end
    end
  end

  // Ratio selection applies to all channels
  always_comb begin
    if (ratio_mode == MODE_POWER) begin
      val[0] = power_l1;
      val[1] = power_l2;
      val[2] = power_l3;
      val[3] = power_r1;
      val[4] = power_r2;
    end else begin
      val[0] = ampl_l1;
      val[1] = ampl_l2;
      val[2] = ampl_l3;
      val[3] = ampl_r1;
      val[4] = ampl_r2;
    end
  end

  // Highest phase against the one shared phase limit
  always_comb begin
    chan_val[0] = val[0];
    if (val[1] > chan_val[0]) begin
      chan_val[0] = val[1];
    end
    if (val[2] > chan_val[0]) begin
      chan_val[0] = val[2];
    end
    chan_val[1] = val[3];
    chan_val[2] = val[4];
  end

  // One channel per group member
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      localparam int unsigned IDX = g;
      dam_channel u_ch (
        .clk(clk),
        .rst(rst),
        .cycle_en(cycle_r),
        .tick_ms(tick_ms_r),
        .enable_n(enable_n_grp[setting_group*NCH + IDX]),
        .limit(limit_grp[(setting_group*NCH + IDX)*14 +: 14]),
        .delay_steps(delay_grp[(setting_group*NCH + IDX)*19 +: 19]),
        .value(chan_val[g]),
        .block(block_s_r),
        .start_r(ch_start[g]),
        .alarm_r(ch_alarm[g]),
        .blocked_r(ch_blocked[g])
      );
    end
  endgenerate

  // Outputs and status code
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_out_r <= '0;
      alarm_out_r <= '0;
      blocked_out_r <= 1'b0;
      monitor_state_code_r <= DAM_NORMAL;
    end else begin
      start_out_r <= ch_start;
      alarm_out_r <= ch_alarm;
      blocked_out_r <= |ch_blocked;
      if (|ch_blocked) begin
        monitor_state_code_r <= DAM_BLOCKED;
      end else if (|ch_alarm) begin
        monitor_state_code_r <= DAM_ALARM;
      end else if (|ch_start) begin
        monitor_state_code_r <= DAM_START;
      end else begin
        monitor_state_code_r <= DAM_NORMAL;
      end
    end
  end

  // Fourteen event sources, even ids ON and odd ids OFF
  genvar e;
  generate
    for (e = 0; e < NCH; e++) begin : g_ev
      assign now_v[2*e] = ch_start[e];
      assign now_v[2*e+1] = ch_start[e];
      assign now_v[6+2*e] = ch_alarm[e];
      assign now_v[6+2*e+1] = ch_alarm[e];
    end
  endgenerate
  assign now_v[12] = |ch_blocked;
  assign now_v[13] = |ch_blocked;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_r <= '0;
    end else begin
      prev_r <= now_v;
    end
  end

  genvar b;
  generate
    for (b = 0; b < NEV; b++) begin : g_edge
      if (b % 2 == 0) begin : g_on
        assign rise[b] = now_v[b] && !prev_r[b];
        assign fall[b] = 1'b0;
      end else begin : g_off
        assign rise[b] = 1'b0;
        assign fall[b] = !now_v[b] && prev_r[b];
      end
    end
  endgenerate

  // Pending events, masked; new edge wins over the serve clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_r <= '0;
    end else begin
      pend_r <= (pend_r & ~(pick_any ? (NEV'(1) << pick_id) : '0)) | ((rise | fall) & event_mask);
    end
  end

  always_comb begin
    pick_any = 1'b0;
    pick_id = '0;
    for (int i = NEV - 1; i >= 0; i--) begin
      if (pend_r[i]) begin
        pick_any = 1'b1;
        pick_id = 4'(i);
      end
    end
  end

  assign snap = {val[0], val[1], val[2]};

  // Stamped event with process data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_valid_r <= 1'b0;
      ev_id_r <= '0;
      ev_time_r <= '0;
      ev_data_r <= '0;
      ev_group_r <= '0;
    end else begin
      ev_valid_r <= pick_any;
      ev_id_r <= pick_id;
      ev_time_r <= stamp_r[39:0];
      ev_data_r <= snap;
      ev_group_r <= setting_group;
    end
  end

  // Log only ON events: time, id, upper bits of each phase, group
  assign log_wr = pick_any && !pick_id[0];
  assign log_wd = {stamp_r[39:0], pick_id, snap[41:36], snap[27:22], snap[13:9], setting_group};

  dam_log u_log (
    .clk(clk),
    .rst(rst),
    .wr_en(log_wr),
    .wr_data(log_wd),
    .rd_idx(log_idx),
    .rd_data(log_rd),
    .count_r(log_cnt),
    .head_r()
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      log_data_r <= '0;
      log_count_r <= '0;
    end else begin
      log_data_r <= log_rd;
      log_count_r <= log_cnt;
    end
  end
endmodule : dam_top
`default_nettype wire

// ===== shared/dam_pkg.sv
/*
 Constants, types and timing for the distortion alarm monitor.
 Assumes a 40 MHz clock and distortion values in 0.01 % units.
*/
package dam_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned MS_PER_SEC = 1000;
  localparam int unsigned STAMP_MS = 1;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_SEC * STAMP_MS;
  localparam int unsigned DELAY_STEP_MS = 5;
  localparam int unsigned NCH = 3;
  localparam int unsigned NGRP = 8;
  localparam int unsigned LOG_DEPTH = 12;
  localparam int unsigned NEV = 14;
  localparam logic [13:0] LIMIT_DEFAULT = 14'h03E8;
  localparam logic [18:0] DELAY_DEFAULT = 19'h007D0;
  localparam logic ENABLED = 1'b0;
  localparam logic [1:0] MODE_AMPL = 2'h1;
  localparam logic [1:0] MODE_POWER = 2'h2;
  localparam int unsigned REL_NUM = 97;
  localparam int unsigned REL_DEN = 100;
  typedef enum logic [1:0] {
    DAM_NORMAL = 2'b00,
    DAM_START = 2'b01,
    DAM_ALARM = 2'b10,
    DAM_BLOCKED = 2'b11
  } dam_state_t;
  // Event ids: start ch*2+off, alarm 6+ch*2+off, blocked 12+off
  localparam logic [3:0] EV_START_BASE = 4'h0;
  localparam logic [3:0] EV_ALARM_BASE = 4'h6;
  localparam logic [3:0] EV_BLOCK_BASE = 4'hC;
endpackage : dam_pkg

// ===== sim/dam_meas_model.sv
/*
 Upstream model: value strobe and blocking matrix.
 Assumes the bench sets block_req at falling edges.
*/
`timescale 1ns/100ps
`default_nettype none
module dam_meas_model #(
  parameter int unsigned PERIOD = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench request
  input wire logic block_req,
  // Towards the monitor
  output logic new_values,
  output logic block_in
);
  int unsigned cnt_r;
  // Shortened value period, one strobe per set
  always_ff @(negedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 0;
      new_values <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
      new_values <= (cnt_r == 0);
    end
  end
  // Passed on at once, far ahead of any delay expiry
  always_ff @(negedge clk or posedge rst) begin
    if (rst) begin
      block_in <= 1'b0;
    end else begin
      block_in <= block_req;
    end
  end
endmodule : dam_meas_model
`default_nettype wire

// ===== sim/dam_top_assertions.sv
/*
 Port checker for dam_top.
 Assumes mask and settings change only while no event is pending.
*/
`timescale 1ns/100ps
`default_nettype none
module dam_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Inputs
  input wire logic new_values,
  input wire logic [2:0] setting_group,
  input wire logic [23:0] enable_n_grp,
  input wire logic block_in,
  input wire logic force_mode,
  input wire logic force_block,
  input wire logic [13:0] event_mask,
  // Outputs
  input wire logic [2:0] start_out_r,
  input wire logic [2:0] alarm_out_r,
  input wire logic blocked_out_r,
  input wire dam_pkg::dam_state_t monitor_state_code_r,
  input wire logic ev_valid_r,
  input wire logic [3:0] ev_id_r
);
  import dam_pkg::*;
  logic blk;
  assign blk = force_mode ? force_block : block_in;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_norm;
    (start_out_r | alarm_out_r) == 3'h0 && !blocked_out_r |-> monitor_state_code_r == DAM_NORMAL;
  endproperty
  a_norm: assert property (p_norm) else $error("state not normal");
  property p_alarm;
    |alarm_out_r && !blocked_out_r |-> monitor_state_code_r == DAM_ALARM;
  endproperty
  a_alarm: assert property (p_alarm) else $error("state not alarm");
  property p_blkst;
    blocked_out_r && (start_out_r | alarm_out_r) == 3'h0 |-> monitor_state_code_r == DAM_BLOCKED;
  endproperty
  a_blkst: assert property (p_blkst) else $error("state not blocked");
  property p_alst;
    $rose(alarm_out_r[0]) |-> start_out_r[0];
  endproperty
  a_alst: assert property (p_alst) else $error("alarm without start");
  property p_nv;
    $rose(start_out_r[0]) |-> $past(new_values, 4);
  endproperty
  a_nv: assert property (p_nv) else $error("start off the cycle");
  property p_nb;
    $rose(start_out_r[0]) |-> !$past(blk, 4);
  endproperty
  a_nb: assert property (p_nb) else $error("start while blocked");
  property p_en;
    $rose(start_out_r[2]) |-> enable_n_grp[setting_group * 3 + 2] == ENABLED;
  endproperty
  a_en: assert property (p_en) else $error("start while disabled");
  property p_mask;
    ev_valid_r |-> event_mask[ev_id_r];
  endproperty
  a_mask: assert property (p_mask) else $error("masked event sent");
endmodule : dam_chk
bind dam_top dam_chk u_chk (.clk, .rst, .new_values, .setting_group, .enable_n_grp, .block_in, .force_mode,
  .force_block, .event_mask, .start_out_r, .alarm_out_r, .blocked_out_r, .monitor_state_code_r, .ev_valid_r,
  .ev_id_r);
`default_nettype wire

// ===== sim/tb_top.sv
/*
 Self-checking bench for dam_top.
 Assumes the upstream model strobes values every 16 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dam_pkg::*;
  logic clk, rst, new_values, block_in, blk_req, force_mode, force_block, blocked_out_r, ev_valid_r;
  logic [13:0] ampl_l1, ampl_l2, ampl_l3, ampl_r1, ampl_r2, power_l1, power_l2, power_l3, power_r1, power_r2;
  logic [1:0] ratio_mode;
  logic [23:0] enable_n_grp;
  logic [335:0] limit_grp;
  logic [13:0] event_mask;
  logic [39:0] time_ms_in, ev_time_r;
  logic [2:0] start_out_r, alarm_out_r;
  logic [3:0] ev_id_r, log_count_r, log_idx;
  logic [2:0] setting_group, ev_group_r;
  logic [455:0] delay_grp;
  logic [41:0] ev_data_r;
  logic [63:0] log_data_r;
  logic [88:0] exp_q [$];
  logic [15:0] lfsr = 16'h92FF;
  dam_state_t monitor_state_code_r;
  int error_cnt = 0, samples_checked = 0, cyc = 0, i;
  dam_meas_model #(.PERIOD(16)) u_src (.clk, .rst, .block_req(blk_req), .new_values, .block_in);
  dam_top DUT (.clk, .rst, .new_values, .ampl_l1, .ampl_l2, .ampl_l3, .ampl_r1, .ampl_r2, .power_l1,
    .power_l2, .power_l3, .power_r1, .power_r2, .ratio_mode, .setting_group, .enable_n_grp, .limit_grp,
    .delay_grp, .block_in, .force_mode, .force_block, .event_mask, .time_ms_in, .start_out_r,
    .alarm_out_r, .blocked_out_r, .monitor_state_code_r, .ev_valid_r, .ev_id_r, .ev_time_r, .ev_data_r,
    .ev_group_r, .log_idx, .log_data_r, .log_count_r);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [13:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[13:0];
  endfunction : rnd
  task automatic cmp_out(input string nm, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : cmp_out
  task automatic cmp_ev(input logic [88:0] e, input logic [88:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH event exp %h got %h", e, g);
    end
  endtask : cmp_ev
  task automatic note(input logic [3:0] id);
    exp_q.push_back({id, time_ms_in, setting_group, power_l1, power_l2, power_l3});
  endtask : note
  task automatic setp(input logic [13:0] a, b, c, d, e);
    {power_l1, power_l2, power_l3, power_r1, power_r2} = {a, b, c, d, e};
  endtask : setp
  task automatic settle();
    repeat (48) @(negedge clk);
    time_ms_in = time_ms_in + 40'h1;
  endtask : settle
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // Each event takes the oldest note
  always @(negedge clk) begin
    if (ev_valid_r === 1'b1) begin
      if (exp_q.size() > 0) cmp_ev(exp_q.pop_front(), {ev_id_r, ev_time_r, ev_group_r, ev_data_r});
      else cmp_ev({4'hF, 85'h0}, {ev_id_r, ev_time_r, ev_group_r, ev_data_r});
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    rst = 1'b1;
    {blk_req, force_mode, force_block} = 3'h0;
    {ampl_l1, ampl_l2, ampl_l3, ampl_r1, ampl_r2} = 70'h0;
    setp(14'h0, 14'h0, 14'h0, 14'h0, 14'h0);
    ratio_mode = MODE_AMPL;
    enable_n_grp = 24'h0;
    setting_group = 3'h0;
    delay_grp = 456'h0;
    log_idx = 4'h0;
    limit_grp = {24{LIMIT_DEFAULT}};
    event_mask = 14'h3FFF;
    time_ms_in = 40'h0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (i = 0; i < 8; i++) begin
      {ampl_l1, ampl_l2, ampl_r1} = {rnd() % 14'h03CA, rnd() % 14'h03CA, rnd() % 14'h03CA};
      {ampl_l3, ampl_r2} = {14'h03E8, rnd() % 14'h03CA};
      setp(rnd(), rnd(), rnd(), rnd(), rnd());
      settle();
      cmp_out("start", 16'h0, 16'(start_out_r));
      cmp_out("state", 16'(DAM_NORMAL), 16'(monitor_state_code_r));
    end
    $display("test quiet done");
    {ampl_l1, ampl_l2, ampl_l3, ampl_r1, ampl_r2} = 70'h0;
    setp(14'h0, 14'h03E9, 14'h0, 14'h0, 14'h0);
    settle();
    cmp_out("ampl mode", 16'h0, 16'(start_out_r));
    ratio_mode = MODE_POWER;
    note(4'h0);
    note(4'h6);
    settle();
    cmp_out("start", 16'h1, 16'(start_out_r));
    cmp_out("alarm", 16'h1, 16'(alarm_out_r));
    cmp_out("state", 16'(DAM_ALARM), 16'(monitor_state_code_r));
    cmp_out("log count", 16'h2, 16'(log_count_r));
    cmp_out("log entry", {time_ms_in - 40'h1, 4'h0, 6'h00, 6'h03, 5'h00, 3'h0}, log_data_r);
    power_l2 = 14'h03CA;
    settle();
    cmp_out("hold", 16'h1, 16'(start_out_r));
    power_l2 = 14'h03C9;
    note(4'h1);
    note(4'h7);
    settle();
    cmp_out("release", 16'h0, 16'(start_out_r | alarm_out_r));
    for (i = 0; i < 4; i++) begin
      power_l1 = 14'h03E9;
      note(4'h0);
      note(4'h6);
      settle();
      power_l1 = 14'h0;
      note(4'h1);
      note(4'h7);
      settle();
    end
    $display("test phase done");
    event_mask = 14'h1FFF;
    {force_mode, force_block, power_r2} = {2'h3, 14'h03E9};
    note(4'hC);
    settle();
    cmp_out("blocked", 16'h1, 16'(blocked_out_r));
    cmp_out("forced", 16'h0, 16'(start_out_r));
    cmp_out("state", 16'(DAM_BLOCKED), 16'(monitor_state_code_r));
    {force_mode, power_r2} = 15'h0;
    settle();
    cmp_out("unblocked", 16'h0, 16'(blocked_out_r));
    event_mask = 14'h0FFF;
    power_r1 = 14'h03E9;
    note(4'h2);
    note(4'h8);
    settle();
    blk_req = 1'b1;
    note(4'h3);
    note(4'h9);
    settle();
    cmp_out("late block", 16'h0, 16'(start_out_r | alarm_out_r));
    {blk_req, power_r1} = 15'h0;
    settle();
    $display("test blocking done");
    {event_mask, enable_n_grp, power_r2} = {14'h3FFF, 24'h000004, 14'h03E9};
    settle();
    cmp_out("disabled", 16'h0, 16'(start_out_r));
    enable_n_grp = 24'h0;
    note(4'h4);
    note(4'hA);
    settle();
    cmp_out("start", 16'h4, 16'(start_out_r));
    power_r2 = 14'h0;
    note(4'h5);
    note(4'hB);
    settle();
    cmp_out("log wrap", 16'hC, 16'(log_count_r));
    cmp_out("pending", 16'h0, 16'(exp_q.size()));
    $display("test enable done");
    setting_group = 3'h5;
    limit_grp[224 +: 14] = 14'h0200;
    delay_grp[304 +: 19] = 19'h00001;
    power_r1 = 14'h0201;
    log_idx = 4'h3;
    note(4'h2);
    settle();
    cmp_out("group start", 16'h2, 16'(start_out_r));
    cmp_out("early alarm", 16'h0, 16'(alarm_out_r));
    cmp_out("state", 16'(DAM_START), 16'(monitor_state_code_r));
    cmp_out("log wrapped", {time_ms_in - 40'h1, 4'h2, 6'h00, 6'h03, 5'h00, 3'h5}, log_data_r);
    power_r1 = 14'h0;
    note(4'h3);
    settle();
    cmp_out("timer reset", 16'h0, 16'(start_out_r | alarm_out_r));
    cmp_out("pending", 16'h0, 16'(exp_q.size()));
    $display("test group done");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
